// ---- design/psic_pkg.sv ----
// Shared constants, types and the checksum function of the pressure sensor command block.
package psic_pkg;

   // Bus identity and command codes.
   localparam logic [6:0] I2C_ADDR = 7'h25;
   localparam logic [15:0] CMD_CONT_MF_AVG = 16'h3603;
   localparam logic [15:0] CMD_CONT_MF = 16'h3608;
   localparam logic [15:0] CMD_CONT_DP_AVG = 16'h3615;
   localparam logic [15:0] CMD_CONT_DP = 16'h361e;
   localparam logic [15:0] CMD_TRIG_MF = 16'h3624;
   localparam logic [15:0] CMD_TRIG_DP = 16'h362f;
   localparam logic [15:0] CMD_STOP = 16'h3ff9;

   // Times as printed and their cycle counts at the core clock.
   localparam int CLK_HZ = 10_000_000;
   localparam int T_SAMPLE_US = 500;
   localparam int T_FIRST_MS = 8;
   localparam int T_AVG_MS = 25;
   localparam int T_TRIG_MS = 45;
   localparam int SAMPLE_CYC = T_SAMPLE_US * (CLK_HZ / 1_000_000);
   localparam int FIRST_CYC = T_FIRST_MS * (CLK_HZ / 1000);
   localparam int TRIG_CYC = T_TRIG_MS * (CLK_HZ / 1000);
   localparam int AVG_SAMPLES = (T_AVG_MS * 1000) / T_SAMPLE_US;
   localparam int CNT_W = 20;

   // Smoothing factor 0.05 in unsigned Q0.16.
   localparam logic [15:0] ALPHA_Q16 = 16'h0ccd;

   // Result frame and checksum defaults.
   localparam int FRAME_BYTES = 9;
   localparam logic [3:0] LAST_BYTE = 4'h8;
   localparam logic [7:0] CRC_POLY_DEF = 8'h07;
   localparam logic [7:0] CRC_INIT_DEF = 8'h00;
   localparam logic [15:0] SCALE_DEF = 16'h003c;
   localparam logic [47:0] FRAME_RST = 48'h0;

   typedef enum logic [3:0] {
      MODE_IDLE = 4'h1,
      MODE_WARM = 4'h2,
      MODE_RUN = 4'h4,
      MODE_TRIG = 4'h8
   } psic_mode_e;

   typedef enum logic [6:0] {
      I_IDLE = 7'h01,
      I_ADDR = 7'h02,
      I_AACK = 7'h04,
      I_WR = 7'h08,
      I_WACK = 7'h10,
      I_RD = 7'h20,
      I_RACK = 7'h40
   } psic_i2c_e;

   function automatic logic [7:0] psic_crc8(input logic [15:0] word, input logic [7:0] poly,
                                            input logic [7:0] init);
      logic [7:0] c;
      logic fb;
      c = init;
      for (int i = 15; i >= 0; i--) begin
         fb = c[7] ^ word[i];
         c = {c[6:0], 1'b0} ^ (fb ? poly : 8'h00);
      end
      return c;
   endfunction

endpackage

// ---- design/psic_avg.sv ----
// Average-till-read filter: running mean, then exponential smoothing.
`timescale 1ns/1ns
module psic_avg
   import psic_pkg::*;
#(
   parameter int AVG_N = AVG_SAMPLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Samples
   input wire logic sample_en,
   input wire logic [15:0] sample,
   // Control
   input wire logic avg_en,
   input wire logic restart,
   // Result
   output logic [15:0] value
);

   logic [6:0] n;
   logic signed [22:0] sum;
   logic [6:0] next_n;
   logic signed [22:0] next_sum;
   logic [15:0] next_value;

   always_comb begin
      logic [6:0] base_n;
      logic signed [22:0] base_sum;
      logic signed [22:0] acc;
      logic signed [16:0] diff;
      logic signed [33:0] prod;
      base_n = restart ? 7'h00 : n;
      base_sum = restart ? 23'sh0 : sum;
      acc = base_sum + 23'(signed'(sample));
      diff = 17'(signed'(sample)) - 17'(signed'(value));
      prod = 34'(diff) * 34'(signed'({1'b0, ALPHA_Q16}));
      next_n = base_n;
      next_sum = base_sum;
      next_value = value;
      if (sample_en) begin
         if (!avg_en) begin
            next_value = sample;
         end else if (32'(base_n) < AVG_N) begin
            // Mean over everything since the last read.
            next_sum = acc;
            next_n = base_n + 7'h01;
            next_value = 16'(acc / signed'({16'h0000, base_n + 7'h01}));
         end else begin
            // The 25 ms mean is the starting point of the smoothing.
            next_value = value + prod[31:16];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         n <= 7'h00;
         sum <= 23'sh0;
         value <= 16'h0000;
      end else begin
         n <= next_n;
         sum <= next_sum;
         value <= next_value;
      end
   end

   a_restart_count: assert property (@(posedge clk) disable iff (!rst_n)
      restart && !sample_en |=> n == 7'h00)
      else $error("sample count not cleared by a read");

   a_mean_count: assert property (@(posedge clk) disable iff (!rst_n)
      sample_en && avg_en && !restart && 32'(n) < AVG_N |=> n == $past(n) + 7'h01)
      else $error("mean did not take the new sample");

endmodule // psic_avg

// ---- design/psic_sensor_if.sv ----
// Command interpreter and result path of the pressure sensor's two-wire target.
// Contract
// - Answer as target at address 0x25.
// - Commands are 16 bits, fully decoded.
// - Words MSB first, each followed by checksum.
// - Master NACK and STOP ends cleanly.
// - 0x3603/0x3615 start averaged continuous measurement.
// - 0x3608/0x361E start plain continuous, 0.5 ms.
// - Running mode refreshes results for bare reads.
// - First result readable 8 ms after start.
// - NACK read header while no result exists.
// - Frame: pressure, temperature, scale, each checksummed.
// - Master may stop after any word.
// - New result every 0.5 ms, no faster.
// - One read header delivers all words.
// - Averaging folds in every sample since read.
// - First 25 ms: arithmetic mean.
// - After 25 ms: smoothing, factor 0.05.
// - Each finished measurement lands in result buffer.
// - Triggered: measure 45 ms, NACK, then idle.
`timescale 1ns/1ns
module psic_sensor_if
   import psic_pkg::*;
#(
   parameter int FIRST_CYCLES = FIRST_CYC,
   parameter int SAMPLE_CYCLES = SAMPLE_CYC,
   parameter int TRIG_CYCLES = TRIG_CYC,
   parameter logic [15:0] SCALE_MF = SCALE_DEF,
   parameter logic [15:0] SCALE_DP = SCALE_DEF,
   parameter logic [7:0] CRC_POLY = CRC_POLY_DEF,
   parameter logic [7:0] CRC_INIT = CRC_INIT_DEF
) (
   // Core clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Two-wire link, sampled on its own clock
   input wire logic link_clk,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // Measurement front end
   input wire logic [15:0] adc_press,
   input wire logic [15:0] adc_temp,
   output logic meas_on,
   output logic comp_mass_flow
);

   // Reset release, one copy per domain.
   logic rst_m;
   logic rst_n;
   logic lrst_m;
   logic lrst_n;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_m <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_m <= 1'b1;
         rst_n <= rst_m;
      end
   end

   always_ff @(posedge link_clk or negedge rst_b) begin
      if (!rst_b) begin
         lrst_m <= 1'b0;
         lrst_n <= 1'b0;
      end else begin
         lrst_m <= 1'b1;
         lrst_n <= lrst_m;
      end
   end

   // Crossings. Multi-bit words stay still while their toggle is in flight.
   logic [15:0] cmd_word;
   logic cmd_tog;
   logic rdd_tog;
   logic ack_tog;
   logic [47:0] xfer_data;
   logic xfer_tog;
   logic [2:0] cmd_s;
   logic [2:0] rdd_s;
   logic [1:0] ack_s;
   logic [2:0] req_s;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_s <= 3'h0;
         rdd_s <= 3'h0;
         ack_s <= 2'h0;
      end else begin
         cmd_s <= {cmd_s[1:0], cmd_tog};
         rdd_s <= {rdd_s[1:0], rdd_tog};
         ack_s <= {ack_s[0], ack_tog};
      end
   end

   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         req_s <= 3'h0;
      end else begin
         req_s <= {req_s[1:0], xfer_tog};
      end
   end

   wire cmd_evt = cmd_s[2] ^ cmd_s[1];
   wire rdd_evt = rdd_s[2] ^ rdd_s[1];
   wire busy = xfer_tog ^ ack_s[1];
   wire req_evt = req_s[2] ^ req_s[1];

   // Measurement sequencer on the core clock.
   psic_mode_e mode;
   psic_mode_e next_mode;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic avg_en;
   logic next_avg_en;
   logic next_comp;
   logic next_meas;
   logic pub;
   logic pend;
   logic next_pend;
   logic [15:0] res_t;
   logic [15:0] next_res_t;
   logic [47:0] next_xfer_data;
   logic next_xfer_tog;
   logic sample_en;
   logic avg_restart;
   logic [15:0] avg_value;

   always_comb begin
      next_mode = mode;
      next_cnt = cnt + CNT_W'(1);
      next_avg_en = avg_en;
      next_comp = comp_mass_flow;
      next_res_t = res_t;
      sample_en = 1'b0;
      avg_restart = rdd_evt;
      case (mode)
         MODE_IDLE: begin
            next_cnt = '0;
            if (cmd_evt) begin
               // Full 16-bit compare; anything unlisted leaves the mode alone but clears comp_mass_flow and avg_en.
               next_comp = cmd_word == CMD_CONT_MF_AVG || cmd_word == CMD_CONT_MF
                  || cmd_word == CMD_TRIG_MF;
               next_avg_en = cmd_word == CMD_CONT_MF_AVG || cmd_word == CMD_CONT_DP_AVG;
               if (cmd_word == CMD_CONT_MF_AVG || cmd_word == CMD_CONT_MF
                   || cmd_word == CMD_CONT_DP_AVG || cmd_word == CMD_CONT_DP) begin
                  next_mode = MODE_WARM;
                  avg_restart = 1'b1;
               end else if (cmd_word == CMD_TRIG_MF || cmd_word == CMD_TRIG_DP) begin
                  next_mode = MODE_TRIG;
                  next_avg_en = 1'b0;
               end
            end
         end
         MODE_WARM: begin
            if (cnt == CNT_W'(FIRST_CYCLES - 1)) begin
               next_mode = MODE_RUN;
               next_cnt = '0;
               sample_en = 1'b1;
            end
         end
         MODE_RUN: begin
            if (cnt == CNT_W'(SAMPLE_CYCLES - 1)) begin
               next_cnt = '0;
               sample_en = 1'b1;
            end
         end
         MODE_TRIG: begin
            if (cnt == CNT_W'(TRIG_CYCLES - 1)) begin
               next_mode = MODE_IDLE;
               sample_en = 1'b1;
            end
         end
         default: begin
            next_mode = MODE_IDLE;
         end
      endcase
      // While running, commands other than stop are dropped.
      if (cmd_evt && cmd_word == CMD_STOP && mode != MODE_IDLE) begin
         next_mode = MODE_IDLE;
      end
      if (sample_en) begin
         next_res_t = adc_temp;
      end
      next_meas = next_mode != MODE_IDLE;
      // A result that arrives while the link is busy waits; the newest one goes.
      next_xfer_data = xfer_data;
      next_xfer_tog = xfer_tog;
      next_pend = pend | pub;
      if (pend && !busy) begin
         next_xfer_data = {avg_value, res_t, comp_mass_flow ? SCALE_MF : SCALE_DP};
         next_xfer_tog = ~xfer_tog;
         next_pend = pub;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode <= MODE_IDLE;
         cnt <= '0;
         avg_en <= 1'b0;
         comp_mass_flow <= 1'b0;
         meas_on <= 1'b0;
         pub <= 1'b0;
         pend <= 1'b0;
         res_t <= 16'h0000;
         xfer_data <= FRAME_RST;
         xfer_tog <= 1'b0;
      end else begin
         mode <= next_mode;
         cnt <= next_cnt;
         avg_en <= next_avg_en;
         comp_mass_flow <= next_comp;
         meas_on <= next_meas;
         pub <= sample_en;
         pend <= next_pend;
         res_t <= next_res_t;
         xfer_data <= next_xfer_data;
         xfer_tog <= next_xfer_tog;
      end
   end

   psic_avg #(
      .AVG_N(AVG_SAMPLES)
   ) u_avg (
      .clk(clk),
      .rst_n(rst_n),
      .sample_en(sample_en),
      .sample(adc_press),
      .avg_en(avg_en),
      .restart(avg_restart),
      .value(avg_value)
   );

   // Link side: synchronised pins and edge strobes.
   logic [2:0] scl_s;
   logic [2:0] sda_s;

   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         scl_s <= 3'h7;
         sda_s <= 3'h7;
      end else begin
         scl_s <= {scl_s[1:0], scl_i};
         sda_s <= {sda_s[1:0], sda_i};
      end
   end

   wire scl_rise = scl_s[1] & ~scl_s[2];
   wire scl_fall = ~scl_s[1] & scl_s[2];
   wire start_c = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
   wire stop_c = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];

   psic_i2c_e ist;
   psic_i2c_e next_ist;
   logic [3:0] bitc;
   logic [3:0] next_bitc;
   logic [7:0] sh;
   logic [7:0] next_sh;
   logic rw;
   logic next_rw;
   logic [1:0] wbyte;
   logic [1:0] next_wbyte;
   logic [7:0] cmd_hi;
   logic [7:0] next_cmd_hi;
   logic [15:0] next_cmd_word;
   logic next_cmd_tog;
   logic [3:0] bidx;
   logic [3:0] next_bidx;
   logic [7:0] tx;
   logic [7:0] next_tx;
   logic have_res;
   logic next_have_res;
   logic [47:0] frame;
   logic [47:0] next_frame;
   logic [47:0] frame_pend;
   logic [47:0] next_frame_pend;
   logic pend_new;
   logic next_pend_new;
   logic next_ack_tog;
   logic next_rdd_tog;
   logic rd_any;
   logic next_rd_any;
   logic next_sda_oe;
   logic [15:0] cur_w;
   logic [7:0] cur_b;

   // Byte of the frame at the current index; past the end the line floats high.
   always_comb begin
      cur_w = frame[15:0];
      if (bidx < 4'h3) begin
         cur_w = frame[47:32];
      end else if (bidx < 4'h6) begin
         cur_w = frame[31:16];
      end
      case (bidx)
         4'h0, 4'h3, 4'h6: cur_b = cur_w[15:8];
         4'h1, 4'h4, 4'h7: cur_b = cur_w[7:0];
         4'h2, 4'h5, 4'h8: cur_b = psic_crc8(cur_w, CRC_POLY, CRC_INIT);
         default: cur_b = 8'hff;
      endcase
   end

   always_comb begin
      next_ist = ist;
      next_bitc = bitc;
      next_sh = sh;
      next_rw = rw;
      next_wbyte = wbyte;
      next_cmd_hi = cmd_hi;
      next_cmd_word = cmd_word;
      next_cmd_tog = cmd_tog;
      next_bidx = bidx;
      next_tx = tx;
      next_have_res = have_res;
      next_frame = frame;
      next_frame_pend = frame_pend;
      next_pend_new = pend_new;
      next_ack_tog = ack_tog;
      next_rdd_tog = rdd_tog;
      next_rd_any = rd_any;
      next_sda_oe = sda_oe;
      if (start_c || stop_c) begin
         next_ist = start_c ? I_ADDR : I_IDLE;
         next_bitc = 4'h0;
         next_sda_oe = 1'b0;
         if (rd_any) begin
            next_rdd_tog = ~rdd_tog;
            next_rd_any = 1'b0;
         end
      end else begin
         case (ist)
            I_IDLE: begin
               next_bitc = 4'h0;
            end
            I_ADDR, I_WR: begin
               if (scl_rise) begin
                  next_sh = {sh[6:0], sda_s[1]};
                  next_bitc = bitc + 4'h1;
               end else if (scl_fall && bitc == 4'h8) begin
                  next_ist = I_IDLE;
                  if (ist == I_ADDR) begin
                     next_bidx = 4'h0;
                     next_wbyte = 2'h0;
                     next_rw = sh[0];
                     if (sh[7:1] == I2C_ADDR && (!sh[0] || have_res)) begin
                        next_ist = I_AACK;
                        next_sda_oe = 1'b1;
                     end
                  end else if (wbyte != 2'h2) begin
                     next_ist = I_WACK;
                     next_sda_oe = 1'b1;
                     next_wbyte = wbyte + 2'h1;
                     next_cmd_hi = sh;
                     if (wbyte == 2'h1) begin
                        next_cmd_word = {cmd_hi, sh};
                        next_cmd_tog = ~cmd_tog;
                        next_have_res = 1'b0;
                     end
                  end
               end
            end
            I_AACK, I_WACK: begin
               if (scl_fall) begin
                  next_bitc = 4'h0;
                  next_sda_oe = 1'b0;
                  next_ist = I_WR;
                  if (ist == I_AACK && rw) begin
                     next_ist = I_RD;
                     next_tx = cur_b;
                     next_bitc = 4'h1;
                     next_sda_oe = ~cur_b[7];
                  end
               end
            end
            I_RD: begin
               if (scl_fall) begin
                  if (bitc == 4'h8) begin
                     next_ist = I_RACK;
                     next_sda_oe = 1'b0;
                     next_bidx = (bidx == LAST_BYTE + 4'h1) ? bidx : bidx + 4'h1;
                     if (bidx == 4'h1) begin
                        next_rd_any = 1'b1;
                     end
                  end else begin
                     next_tx = {tx[6:0], 1'b1};
                     next_bitc = bitc + 4'h1;
                     next_sda_oe = ~tx[6];
                  end
               end
            end
            I_RACK: begin
               if (scl_rise && sda_s[1]) begin
                  next_ist = I_IDLE;
               end else if (scl_fall) begin
                  next_ist = I_RD;
                  next_tx = cur_b;
                  next_bitc = 4'h1;
                  next_sda_oe = ~cur_b[7];
               end
            end
            default: begin
               next_ist = I_IDLE;
               next_sda_oe = 1'b0;
            end
         endcase
      end
      // Once a read header is acknowledged the frame stays put, so that no read mixes two results.
      // This sits after the command clear, so that a result landing in the same cycle wins.
      if (pend_new && !(rw && ist == I_AACK) && ist != I_RD && ist != I_RACK) begin
         next_frame = frame_pend;
         next_have_res = 1'b1;
         next_pend_new = 1'b0;
      end
      // A new arrival must not be lost to the swap of the previous one.
      if (req_evt) begin
         next_frame_pend = xfer_data;
         next_pend_new = 1'b1;
         next_ack_tog = req_s[1];
      end
   end

   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         ist <= I_IDLE;
         bitc <= 4'h0;
         sh <= 8'h00;
         rw <= 1'b0;
         wbyte <= 2'h0;
         cmd_hi <= 8'h00;
         cmd_word <= 16'h0000;
         cmd_tog <= 1'b0;
         bidx <= 4'h0;
         tx <= 8'hff;
         have_res <= 1'b0;
         frame <= FRAME_RST;
         frame_pend <= FRAME_RST;
         pend_new <= 1'b0;
         ack_tog <= 1'b0;
         rdd_tog <= 1'b0;
         rd_any <= 1'b0;
         sda_oe <= 1'b0;
         sda_o <= 1'b0;
      end else begin
         ist <= next_ist;
         bitc <= next_bitc;
         sh <= next_sh;
         rw <= next_rw;
         wbyte <= next_wbyte;
         cmd_hi <= next_cmd_hi;
         cmd_word <= next_cmd_word;
         cmd_tog <= next_cmd_tog;
         bidx <= next_bidx;
         tx <= next_tx;
         have_res <= next_have_res;
         frame <= next_frame;
         frame_pend <= next_frame_pend;
         pend_new <= next_pend_new;
         ack_tog <= next_ack_tog;
         rdd_tog <= next_rdd_tog;
         rd_any <= next_rd_any;
         sda_oe <= next_sda_oe;
         sda_o <= 1'b0;
      end
   end

   a_addr_match: assert property (@(posedge link_clk) disable iff (!lrst_n)
      ist == I_AACK && sda_oe |-> sh[7:1] == I2C_ADDR)
      else $error("acknowledged a foreign address");

   a_noresult_nack: assert property (@(posedge link_clk) disable iff (!lrst_n)
      ist == I_ADDR && !start_c && !stop_c && scl_fall && bitc == 4'h8 && sh[0] && !have_res
      |=> ist == I_IDLE && !sda_oe)
      else $error("read header taken with no result");

   a_stop_release: assert property (@(posedge link_clk) disable iff (!lrst_n)
      stop_c |=> !sda_oe && ist == I_IDLE)
      else $error("line held after stop");

   a_frame_first: assert property (@(posedge link_clk) disable iff (!lrst_n)
      ist == I_AACK && rw && scl_fall && !start_c && !stop_c |=> tx == frame[47:40])
      else $error("read did not begin with pressure high byte");

   a_cmd_avg: assert property (@(posedge clk) disable iff (!rst_n)
      mode == MODE_IDLE && cmd_evt && cmd_word == CMD_CONT_MF_AVG
      |=> mode == MODE_WARM && avg_en && comp_mass_flow)
      else $error("averaged start command misdecoded");

   a_first_result: assert property (@(posedge clk) disable iff (!rst_n)
      mode == MODE_WARM && cnt == CNT_W'(FIRST_CYCLES - 1) && !cmd_evt
      |=> mode == MODE_RUN && pub)
      else $error("first result not on time");

   a_sample_gap: assert property (@(posedge clk) disable iff (!rst_n)
      mode == MODE_RUN && sample_en |=> !sample_en [*8])
      else $error("samples closer than the update period");

   a_trig_done: assert property (@(posedge clk) disable iff (!rst_n)
      mode == MODE_TRIG && cnt == CNT_W'(TRIG_CYCLES - 1) |=> mode == MODE_IDLE && pub)
      else $error("triggered measurement did not finish");

endmodule // psic_sensor_if

// ---- dv/psic_master.sv ----
// Two-wire bus master model for the sensor's link pins.
`timescale 1ns/1ns
module psic_master (
   // Link
   input wire logic link_clk,
   input wire logic sda_oe,
   input wire logic sda_o,
   output logic scl,
   output logic sda
);
   logic sda_m = 1'b1;
   logic [7:0] got;
   event got_ev;
   initial scl = 1'b1;
   // The pull-up wins whenever nobody pulls the line low; the target pulls only with a low value.
   assign sda = sda_m & ~(sda_oe & ~sda_o);
   task automatic step(input logic c, input logic d);
      scl = c;
      sda_m = d;
      repeat (5) @(negedge link_clk);
   endtask
   task automatic start();
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
   endtask
   task automatic stop();
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
   endtask
   // Data only moves while the clock is low, so no false start or stop is seen.
   task automatic bit_io(input logic b, output logic r);
      step(1'b0, b);
      step(1'b1, b);
      r = sda;
      step(1'b0, b);
   endtask
   task automatic put(input logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      got = {7'h0, ~r};
      ->got_ev;
   endtask
   task automatic get(input logic last);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         got[i] = r;
      end
      bit_io(last, r);
      ->got_ev;
   endtask
endmodule // psic_master

// ---- dv/pressure_sensor_i2c_cmd_tb.sv ----
// Self-checking bench for the sensor's command and result path.
`timescale 1ns/1ns
module pressure_sensor_i2c_cmd_tb;
   import psic_pkg::*;
   logic clk;
   logic link_clk;
   logic rst_b;
   logic scl;
   logic sda;
   logic sda_oe;
   logic sda_o;
   logic [15:0] adc_press;
   logic [15:0] adc_temp;
   logic meas_on;
   logic comp_mass_flow;
   logic [7:0] exp_q[$];
   int mismatches = 0;
   int checks_done = 0;
   logic [15:0] codes [4] = '{CMD_CONT_MF_AVG, CMD_CONT_MF, CMD_CONT_DP_AVG, CMD_CONT_DP};

   psic_sensor_if #(.FIRST_CYCLES(80), .SAMPLE_CYCLES(10), .TRIG_CYCLES(200)) u_dut (
      .clk(clk), .rst_b(rst_b), .link_clk(link_clk), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
      .sda_oe(sda_oe), .adc_press(adc_press), .adc_temp(adc_temp), .meas_on(meas_on),
      .comp_mass_flow(comp_mass_flow));
   psic_master u_master (.link_clk(link_clk), .sda_oe(sda_oe), .sda_o(sda_o), .scl(scl),
      .sda(sda));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // The link clock runs at its own rate with an arbitrary phase offset.
   initial begin
      link_clk = 1'b0;
      #17;
      forever #32 link_clk = ~link_clk;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: expected %h got %h", $time, exp, got);
      end
   endtask
   function automatic logic [7:0] crc_of(input logic [15:0] w);
      logic [7:0] c;
      c = CRC_INIT_DEF;
      for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? CRC_POLY_DEF : 8'h00);
      return c;
   endfunction
   task automatic hdr(input logic [6:0] a, input logic rd, input logic ack);
      exp_q.push_back({7'h0, ack});
      u_master.start();
      u_master.put({a, rd});
   endtask
   task automatic cmd(input logic [15:0] c);
      hdr(I2C_ADDR, 1'b0, 1'b1);
      exp_q.push_back(8'h01);
      u_master.put(c[15:8]);
      exp_q.push_back(8'h01);
      u_master.put(c[7:0]);
      u_master.stop();
   endtask
   task automatic rd_words(input int n);
      logic [15:0] w [3];
      w = '{adc_press, adc_temp, SCALE_DEF};
      hdr(I2C_ADDR, 1'b1, 1'b1);
      for (int i = 0; i < n; i++) begin
         exp_q.push_back(w[i][15:8]);
         exp_q.push_back(w[i][7:0]);
         exp_q.push_back(crc_of(w[i]));
         for (int j = 0; j < 3; j++) u_master.get(i == n - 1 && j == 2);
      end
      u_master.stop();
   endtask
   task automatic wrap_up();
      $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   initial forever begin
      @(u_master.got_ev);
      chk(u_master.got, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
   end
   // About ten thousand cycles are expected; four times that means a hang.
   initial begin
      repeat (40000) @(posedge clk);
      mismatches++;
      wrap_up();
   end

   initial begin
      rst_b = 1'b0;
      adc_press = 16'h0;
      adc_temp = 16'h0;
      void'($urandom(89));
      repeat (6) @(negedge clk);
      rst_b = 1'b1;
      repeat (4) @(negedge link_clk);
      hdr(7'h24, 1'b0, 1'b0);
      u_master.stop();
      hdr(I2C_ADDR, 1'b1, 1'b0);
      u_master.stop();
      foreach (codes[i]) begin
         @(negedge clk);
         adc_press = 16'($urandom);
         adc_temp = 16'($urandom);
         cmd(codes[i]);
         repeat (120) @(negedge clk);
         chk({6'h0, meas_on, comp_mass_flow}, {6'h0, 1'b1, 1'(i < 2)});
         rd_words(i % 3 + 1);
         repeat (20) @(negedge clk);
         rd_words(3);
         cmd(CMD_STOP);
         repeat (10) @(negedge clk);
         chk({7'h0, meas_on}, 8'h00);
      end
      // Triggered measurement: polled with a refused read header, then read once it is done.
      cmd(CMD_TRIG_MF);
      @(negedge clk);
      chk({6'h0, meas_on, comp_mass_flow}, 8'h03);
      hdr(I2C_ADDR, 1'b1, 1'b0);
      u_master.stop();
      repeat (250) @(negedge clk);
      chk({7'h0, meas_on}, 8'h00);
      rd_words(3);
      wrap_up();
   end
endmodule // pressure_sensor_i2c_cmd_tb
